// ==== src/dfdf_map.svh ====
// constants of the dual field delay fifo: sizes, counts, timing
// assumes the including file needs no other header
`ifndef DFDF_MAP_SVH
`define DFDF_MAP_SVH

`define DFDF_DATA_W        8
`define DFDF_ADDR_W        18
`define DFDF_DEPTH         262144
`define DFDF_LAST_ADDR     18'h3_FFFF
`define DFDF_LB_DEPTH      18'h0_0100
`define DFDF_LB_W          8
`define DFDF_REF_ROW_W     9
`define DFDF_DELAY_MIN     600
`define DFDF_DELAY_MAX     262215
`define DFDF_CLEAR_LOW_MIN 2'h2

`define DFDF_CLK_PERIOD_NS 5
`define DFDF_SER_PERIOD_NS 40
`define DFDF_REF_GAP_NS    320
`define DFDF_SER_DIV       ((`DFDF_SER_PERIOD_NS + `DFDF_CLK_PERIOD_NS - 1) / `DFDF_CLK_PERIOD_NS)
`define DFDF_SER_HALF      (`DFDF_SER_DIV / 2)
`define DFDF_REF_GAP_CYC   (`DFDF_REF_GAP_NS / `DFDF_CLK_PERIOD_NS)
`define DFDF_DIV_W         4
`define DFDF_REF_CNT_W     7

`endif

// ==== src/dfdf_pkg.sv ====
// types shared by both ends of the dual field delay fifo
// assumes dfdf_map.svh is on the include path
`include "dfdf_map.svh"

package dfdf_pkg;

	typedef logic [`DFDF_DATA_W-1:0] dfdf_word_t;
	typedef logic [`DFDF_ADDR_W-1:0] dfdf_ptr_t;

	typedef struct packed {
		logic       clear;
		logic       gate;
		logic       mask;
		dfdf_word_t data;
	} dfdf_wr_s;

	typedef struct packed {
		logic clear;
		logic gate;
		logic drive;
	} dfdf_rd_s;

	// pointer step with wrap past the last word
	function automatic dfdf_ptr_t ptr_next(input dfdf_ptr_t p);
		ptr_next = (p == `DFDF_LAST_ADDR) ? '0 : p + 18'h0_0001;
	endfunction

endpackage

// ==== src/dfdf_if.sv ====
// pins between the fifo device and the video logic that drives it
// assumes the testbench resolves the output bus from its enable
`timescale 1ns/10ps

interface dfdf_if;
	logic                 write_clock_chan_a;
	logic                 write_clock_chan_b;
	logic                 shared_read_clock;
	logic                 write_gate_chan_a;
	logic                 write_gate_chan_b;
	logic                 write_mask_chan_a;
	logic                 write_mask_chan_b;
	logic                 read_gate_chan_a;
	logic                 read_gate_chan_b;
	logic                 output_drive_chan_a;
	logic                 output_drive_chan_b;
	logic                 write_pointer_clear_a;
	logic                 write_pointer_clear_b;
	logic                 read_pointer_clear_a;
	logic                 read_pointer_clear_b;
	dfdf_pkg::dfdf_word_t input_bus_chan_a;
	dfdf_pkg::dfdf_word_t input_bus_chan_b;
	dfdf_pkg::dfdf_word_t output_bus_chan_a;
	dfdf_pkg::dfdf_word_t output_bus_chan_b;
	logic                 output_bus_oe_chan_a;
	logic                 output_bus_oe_chan_b;

	modport device (
		input  write_clock_chan_a, write_clock_chan_b, shared_read_clock,
		input  write_gate_chan_a, write_gate_chan_b, write_mask_chan_a, write_mask_chan_b,
		input  read_gate_chan_a, read_gate_chan_b, output_drive_chan_a, output_drive_chan_b,
		input  write_pointer_clear_a, write_pointer_clear_b,
		input  read_pointer_clear_a, read_pointer_clear_b,
		input  input_bus_chan_a, input_bus_chan_b,
		output output_bus_chan_a, output_bus_chan_b, output_bus_oe_chan_a, output_bus_oe_chan_b
	);

	modport host (
		output write_clock_chan_a, write_clock_chan_b, shared_read_clock,
		output write_gate_chan_a, write_gate_chan_b, write_mask_chan_a, write_mask_chan_b,
		output read_gate_chan_a, read_gate_chan_b, output_drive_chan_a, output_drive_chan_b,
		output write_pointer_clear_a, write_pointer_clear_b,
		output read_pointer_clear_a, read_pointer_clear_b,
		output input_bus_chan_a, input_bus_chan_b,
		input  output_bus_chan_a, output_bus_chan_b, output_bus_oe_chan_a, output_bus_oe_chan_b
	);
endinterface // dfdf_if

// ==== src/dfdf_chan.sv ====
// one fifo channel: storage, line buffer, pointers, read register, refresh slot
// assumes one-cycle event strobes and controls already synchronised to clock
`timescale 1ns/10ps
`include "dfdf_map.svh"

module dfdf_chan (
	input  logic                 clock,
	input  logic                 rst_n,
	input  logic                 wr_evt,
	input  dfdf_pkg::dfdf_wr_s   wr_ctl,
	input  logic                 rd_evt,
	input  dfdf_pkg::dfdf_rd_s   rd_ctl,
	input  logic                 ref_req,
	output dfdf_pkg::dfdf_word_t rd_data_r,
	output logic                 rd_oe_r,
	output logic                 ref_grant
);

	dfdf_pkg::dfdf_word_t mem [`DFDF_DEPTH];
	dfdf_pkg::dfdf_word_t lb  [256];
	dfdf_pkg::dfdf_ptr_t  wptr_r;
	dfdf_pkg::dfdf_ptr_t  rptr_r;
	dfdf_pkg::dfdf_ptr_t  ref_addr_r;
	logic                 wr_store;
	logic                 rd_step;

	// clear wins over gate and mask in its cycle
	assign wr_store  = wr_evt && !wr_ctl.clear && wr_ctl.gate && wr_ctl.mask; // [RULE_03] [RULE_07]
	assign rd_step   = rd_evt && !rd_ctl.clear && rd_ctl.gate;                // [RULE_11] [RULE_13]
	// refresh only takes idle cycles, so serial access never waits
	assign ref_grant = ref_req && !wr_evt && !rd_evt;                         // [RULE_17]

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r <= '0;
		end else if (wr_evt) begin
			if (wr_ctl.clear) begin
				wptr_r <= '0;                              // [RULE_02]
			end else if (wr_ctl.gate) begin
				wptr_r <= dfdf_pkg::ptr_next(wptr_r);      // [RULE_05] [RULE_07] [RULE_19]
			end
		end
	end

	// masked-off words keep their old contents
	always_ff @(posedge clock) begin
		if (wr_store) begin
			mem[wptr_r] <= wr_ctl.data;                    // [RULE_08]
		end else if (ref_grant) begin
			mem[ref_addr_r] <= mem[ref_addr_r];            // [RULE_17]
		end
	end

	// the first words of a field also land here for zero-latency first access
	always_ff @(posedge clock) begin
		if (wr_store && wptr_r < `DFDF_LB_DEPTH) begin
			lb[wptr_r[`DFDF_LB_W-1:0]] <= wr_ctl.data;     // [RULE_16]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_addr_r <= '0;
		end else if (ref_grant) begin
			ref_addr_r <= dfdf_pkg::ptr_next(ref_addr_r);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rptr_r    <= '0;
			rd_data_r <= '0;
		end else if (rd_evt && rd_ctl.clear) begin
			rptr_r <= '0;                                  // [RULE_10]
		end else if (rd_step) begin
			rd_data_r <= (rptr_r < `DFDF_LB_DEPTH) ? lb[rptr_r[`DFDF_LB_W-1:0]] : mem[rptr_r]; // [RULE_16]
			rptr_r    <= dfdf_pkg::ptr_next(rptr_r);       // [RULE_13] [RULE_19]
		end
	end

	// drive level follows its input on every non-clear edge, gated or not
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_oe_r <= 1'b0;
		end else if (rd_evt && !rd_ctl.clear) begin
			rd_oe_r <= rd_ctl.drive;                       // [RULE_14]
		end
	end

endmodule // dfdf_chan

// ==== src/dfdf_device.sv ====
// device end of the dual field delay fifo: pin sampling, edge detection,
// cascade delay, refresh scheduling and two channel instances
// assumes all pins are asynchronous to clock and serial clocks run well below clock/4
//
// Functional notes
// RULE_01 - two channels, own write clocks, shared read
// RULE_02 - write clear edge zeroes write pointer
// RULE_03 - write clear edge ignores gate and mask
// RULE_04 - controller keeps write clear low two cycles
// RULE_05 - write gate high stores and steps pointer
// RULE_06 - stopped clocks keep all state indefinitely
// RULE_07 - mask low skips store, pointer still steps
// RULE_08 - masked locations keep old contents
// RULE_09 - controller sets write controls before rising edge
// RULE_10 - read clear edge zeroes read pointer
// RULE_11 - read clear edge ignores gate and drive
// RULE_12 - controller keeps read clear low two cycles
// RULE_13 - read gate high steps pointer, shifts word
// RULE_14 - drive controls outputs, pointer steps regardless
// RULE_15 - clear spacing sets delay, 600 to 262215; here spacings past the 262144-word depth overwrite words before they are read
// RULE_16 - line buffer gives first word without latency
// RULE_17 - internal refresh arbitrated against serial access
// RULE_18 - cascade select delays access one cycle
// RULE_19 - pointers wrap to zero past last word
`timescale 1ns/10ps
`include "dfdf_map.svh"

module dfdf_device (
	input  logic clock,
	input  logic rst_n,
	input  logic cascade_select,
	dfdf_if.device pins
);

	////////////////////////////////////////////////////////////////////////////
	// raw pin groups

	dfdf_pkg::dfdf_wr_s wr_raw  [2];
	dfdf_pkg::dfdf_wr_s wr_s1   [2];
	dfdf_pkg::dfdf_wr_s wr_s2   [2];
	dfdf_pkg::dfdf_wr_s wr_prev [2];
	dfdf_pkg::dfdf_wr_s wr_eff  [2];
	dfdf_pkg::dfdf_rd_s rd_raw  [2];
	dfdf_pkg::dfdf_rd_s rd_s1   [2];
	dfdf_pkg::dfdf_rd_s rd_s2   [2];
	dfdf_pkg::dfdf_rd_s rd_prev [2];
	dfdf_pkg::dfdf_rd_s rd_eff  [2];
	dfdf_pkg::dfdf_word_t rd_data [2];

	logic [1:0] wclk_raw;
	logic [1:0] wclk_s1;
	logic [1:0] wclk_s2;
	logic [1:0] wclk_s3;
	logic [1:0] wr_rise;
	logic       rclk_s1;
	logic       rclk_s2;
	logic       rclk_s3;
	logic       rd_rise;
	logic       cas_s1;
	logic       cas_s2;
	logic [1:0] rd_oe;
	logic [1:0] ref_grant;
	logic [1:0] ref_pend_r;
	logic       ref_tick;
	logic [`DFDF_REF_CNT_W-1:0] ref_cnt_r;

	// one write clock per channel, a single read clock for both
	assign wclk_raw = {pins.write_clock_chan_b, pins.write_clock_chan_a}; // [RULE_01]

	assign wr_raw[0] = '{clear: pins.write_pointer_clear_a,
		gate: pins.write_gate_chan_a,
		mask: pins.write_mask_chan_a,
		data: pins.input_bus_chan_a};
	assign wr_raw[1] = '{clear: pins.write_pointer_clear_b,
		gate: pins.write_gate_chan_b,
		mask: pins.write_mask_chan_b,
		data: pins.input_bus_chan_b};
	assign rd_raw[0] = '{clear: pins.read_pointer_clear_a,
		gate: pins.read_gate_chan_a,
		drive: pins.output_drive_chan_a};
	assign rd_raw[1] = '{clear: pins.read_pointer_clear_b,
		gate: pins.read_gate_chan_b,
		drive: pins.output_drive_chan_b};

	////////////////////////////////////////////////////////////////////////////
	// synchronisers: clocks and controls take the same two stages, so the
	// controls seen at a detected edge are the levels set up before that edge

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wclk_s1 <= '0;
			wclk_s2 <= '0;
			wclk_s3 <= '0;
		end else begin
			wclk_s1 <= wclk_raw;
			wclk_s2 <= wclk_s1;
			wclk_s3 <= wclk_s2;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rclk_s1 <= 1'b0;
			rclk_s2 <= 1'b0;
			rclk_s3 <= 1'b0;
		end else begin
			rclk_s1 <= pins.shared_read_clock;
			rclk_s2 <= rclk_s1;
			rclk_s3 <= rclk_s2;
		end
	end

	// strap level, meant to stay fixed during operation
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cas_s1 <= 1'b0;
			cas_s2 <= 1'b0;
		end else begin
			cas_s1 <= cascade_select;
			cas_s2 <= cas_s1;
		end
	end

	// edges only; a stopped clock simply yields no events, so pointers and stored words hold
	assign wr_rise = wclk_s2 & ~wclk_s3; // [RULE_06] [RULE_09]
	assign rd_rise = rclk_s2 & ~rclk_s3; // [RULE_06]

	////////////////////////////////////////////////////////////////////////////
	// per-channel control staging

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_chan
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					wr_s1[c] <= '0;
					wr_s2[c] <= '0;
				end else begin
					wr_s1[c] <= wr_raw[c];
					wr_s2[c] <= wr_s1[c];
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					rd_s1[c] <= '0;
					rd_s2[c] <= '0;
				end else begin
					rd_s1[c] <= rd_raw[c];
					rd_s2[c] <= rd_s1[c];
				end
			end

			// controls of the previous serial edge, for cascade operation
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					wr_prev[c] <= '0;
				end else if (wr_rise[c]) begin
					wr_prev[c] <= wr_s2[c];
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					rd_prev[c] <= '0;
				end else if (rd_rise) begin
					rd_prev[c] <= rd_s2[c];
				end
			end

			assign wr_eff[c] = cas_s2 ? wr_prev[c] : wr_s2[c]; // [RULE_18]
			assign rd_eff[c] = cas_s2 ? rd_prev[c] : rd_s2[c]; // [RULE_18]

			// set wins over the grant that would clear it
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					ref_pend_r[c] <= 1'b0;
				end else if (ref_tick) begin
					ref_pend_r[c] <= 1'b1;                       // [RULE_17]
				end else if (ref_grant[c]) begin
					ref_pend_r[c] <= 1'b0;
				end
			end

			// delay is whatever spacing the controller gives its clears; any
			// spacing inside the depth works, as the line buffer only copies the first words
			dfdf_chan u_chan (
				.clock     (clock),
				.rst_n     (rst_n),
				.wr_evt    (wr_rise[c]),
				.wr_ctl    (wr_eff[c]),
				.rd_evt    (rd_rise),
				.rd_ctl    (rd_eff[c]),
				.ref_req   (ref_pend_r[c]),
				.rd_data_r (rd_data[c]),
				.rd_oe_r   (rd_oe[c]),
				.ref_grant (ref_grant[c])
			); // [RULE_01] [RULE_15]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// refresh interval timer, free running

	assign ref_tick = (ref_cnt_r == `DFDF_REF_CNT_W'(`DFDF_REF_GAP_CYC - 1));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_r <= '0;
		end else if (ref_tick) begin
			ref_cnt_r <= '0;
		end else begin
			ref_cnt_r <= ref_cnt_r + `DFDF_REF_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins; enables are high while the bus is driven

	assign pins.output_bus_chan_a    = rd_data[0];
	assign pins.output_bus_chan_b    = rd_data[1];
	assign pins.output_bus_oe_chan_a = rd_oe[0];   // [RULE_14]
	assign pins.output_bus_oe_chan_b = rd_oe[1];   // [RULE_14]

endmodule // dfdf_device

// ==== src/dfdf_host.sv ====
// controller end: makes serial clocks by division, presents controls on the
// falling edge, spaces clears, and collects read words
// assumes user requests are held until the matching taken pulse
`timescale 1ns/10ps
`include "dfdf_map.svh"

module dfdf_host (
	input  logic                 clock,
	input  logic                 rst_n,
	dfdf_if.host                 pins,
	input  dfdf_pkg::dfdf_word_t host_wr_data  [2],
	input  logic [1:0]           host_wr_gate,
	input  logic [1:0]           host_wr_mask,
	input  logic [1:0]           host_wr_clear,
	output logic [1:0]           host_wr_taken,
	input  logic [1:0]           host_rd_gate,
	input  logic [1:0]           host_rd_drive,
	input  logic [1:0]           host_rd_clear,
	output logic [1:0]           host_rd_taken,
	output dfdf_pkg::dfdf_word_t host_rd_data  [2],
	output logic [1:0]           host_rd_valid
);

	// index 0,1 write clocks, 2 read clock
	logic [`DFDF_DIV_W-1:0] cnt_r [3];
	logic [2:0]             sclk_r;
	logic [2:0]             rise;
	logic [2:0]             fall;
	dfdf_pkg::dfdf_wr_s     wpin_r [2];
	dfdf_pkg::dfdf_rd_s     rpin_r [2];
	logic [1:0]             wguard_r [2];
	logic [1:0]             rguard_r [2];
	logic [1:0]             iss_r;
	logic [1:0]             act_r;
	dfdf_pkg::dfdf_word_t   out_s1 [2];
	dfdf_pkg::dfdf_word_t   out_s2 [2];
	dfdf_pkg::dfdf_word_t   out_raw [2];

	assign out_raw[0] = pins.output_bus_chan_a;
	assign out_raw[1] = pins.output_bus_chan_b;

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_div
			assign rise[k] = (cnt_r[k] == `DFDF_DIV_W'(`DFDF_SER_DIV - 1));
			assign fall[k] = (cnt_r[k] == `DFDF_DIV_W'(`DFDF_SER_HALF - 1));
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					cnt_r[k]  <= '0;
					sclk_r[k] <= 1'b0;
				end else begin
					cnt_r[k] <= rise[k] ? '0 : cnt_r[k] + `DFDF_DIV_W'(1);
					if (rise[k]) begin
						sclk_r[k] <= 1'b1;
					end else if (fall[k]) begin
						sclk_r[k] <= 1'b0;
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		for (k = 0; k < 2; k++) begin : g_chan
			// controls change at the falling edge, stable at the rising one
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					wpin_r[k]        <= '0;
					wguard_r[k]      <= '0;
					host_wr_taken[k] <= 1'b0;
				end else begin
					host_wr_taken[k] <= 1'b0;
					if (fall[k]) begin // [RULE_09]
						if (wguard_r[k] != 2'h0) begin
							wguard_r[k] <= wguard_r[k] - 2'h1;
						end
						if (host_wr_clear[k] && wguard_r[k] != 2'h0) begin
							wpin_r[k] <= '0;                       // [RULE_04]
						end else begin
							wpin_r[k] <= '{clear: host_wr_clear[k], gate: host_wr_gate[k],
								mask: host_wr_mask[k], data: host_wr_data[k]};
							host_wr_taken[k] <= 1'b1;
							if (host_wr_clear[k]) begin
								wguard_r[k] <= `DFDF_CLEAR_LOW_MIN; // [RULE_04]
							end
						end
					end
				end
			end

			// the read clear spacing against the write clear sets the delay
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					rpin_r[k]        <= '0;
					rguard_r[k]      <= '0;
					host_rd_taken[k] <= 1'b0;
					iss_r[k]         <= 1'b0;
				end else begin
					host_rd_taken[k] <= 1'b0;
					if (fall[2]) begin
						if (rguard_r[k] != 2'h0) begin
							rguard_r[k] <= rguard_r[k] - 2'h1;
						end
						if (host_rd_clear[k] && rguard_r[k] != 2'h0) begin
							rpin_r[k] <= '0;                       // [RULE_12]
							iss_r[k]  <= 1'b0;
						end else begin
							rpin_r[k] <= '{clear: host_rd_clear[k], gate: host_rd_gate[k],
								drive: host_rd_drive[k]};         // [RULE_15]
							host_rd_taken[k] <= 1'b1;
							iss_r[k] <= !host_rd_clear[k] && host_rd_gate[k] && host_rd_drive[k];
							if (host_rd_clear[k]) begin
								rguard_r[k] <= `DFDF_CLEAR_LOW_MIN; // [RULE_12]
							end
						end
					end
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					out_s1[k] <= '0;
					out_s2[k] <= '0;
				end else begin
					out_s1[k] <= out_raw[k];
					out_s2[k] <= out_s1[k];
				end
			end

			// a word read at one rising edge is collected just before the next
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					act_r[k]         <= 1'b0;
					host_rd_valid[k] <= 1'b0;
					host_rd_data[k]  <= '0;
				end else begin
					host_rd_valid[k] <= 1'b0;
					if (rise[2]) begin
						act_r[k]         <= iss_r[k];
						host_rd_valid[k] <= act_r[k];
						host_rd_data[k]  <= out_s2[k];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	assign pins.write_clock_chan_a    = sclk_r[0];
	assign pins.write_clock_chan_b    = sclk_r[1];
	assign pins.shared_read_clock     = sclk_r[2];
	assign pins.write_pointer_clear_a = wpin_r[0].clear;
	assign pins.write_pointer_clear_b = wpin_r[1].clear;
	assign pins.write_gate_chan_a     = wpin_r[0].gate;
	assign pins.write_gate_chan_b     = wpin_r[1].gate;
	assign pins.write_mask_chan_a     = wpin_r[0].mask;
	assign pins.write_mask_chan_b     = wpin_r[1].mask;
	assign pins.input_bus_chan_a      = wpin_r[0].data;
	assign pins.input_bus_chan_b      = wpin_r[1].data;
	assign pins.read_pointer_clear_a  = rpin_r[0].clear;
	assign pins.read_pointer_clear_b  = rpin_r[1].clear;
	assign pins.read_gate_chan_a      = rpin_r[0].gate;
	assign pins.read_gate_chan_b      = rpin_r[1].gate;
	assign pins.output_drive_chan_a   = rpin_r[0].drive;
	assign pins.output_drive_chan_b   = rpin_r[1].drive;

endmodule // dfdf_host

// ==== tb/dfdf_pins_sva.sv ====
// checker on the pins between the two fifo ends, channel a in full, channel b output only
// assumes it sits beside the dfdf_if instance and sees the same cascade strap as the device
`timescale 1ns/10ps

module dfdf_pins_sva (
	input logic                 clock,
	input logic                 rst_n,
	input logic                 cascade_select,
	input logic                 write_clock_chan_a,
	input logic                 shared_read_clock,
	input logic                 write_gate_chan_a,
	input logic                 write_mask_chan_a,
	input logic                 write_pointer_clear_a,
	input logic                 read_pointer_clear_a,
	input logic                 read_gate_chan_a,
	input logic                 output_drive_chan_a,
	input dfdf_pkg::dfdf_word_t input_bus_chan_a,
	input dfdf_pkg::dfdf_word_t output_bus_chan_a,
	input dfdf_pkg::dfdf_word_t output_bus_chan_b,
	input logic                 output_bus_oe_chan_a
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// outputs move only a few cycles after a read edge, which stays high 4 samples;
	// in cascade the controls acted on are those of the previous edge, 10 samples back
	AST_DATA_A_GATED: assert property (!$stable(output_bus_chan_a) |->
		$past(shared_read_clock, 2) && (cascade_select ? $past(read_gate_chan_a, 10) : $past(read_gate_chan_a, 2)))
		else $error("data a moved without gated read");
	AST_DATA_A_NO_CLEAR: assert property (!$stable(output_bus_chan_a) |->
		!(cascade_select ? $past(read_pointer_clear_a, 10) : $past(read_pointer_clear_a, 2)))
		else $error("data a moved on a clear edge");
	AST_DATA_B_READ_EDGE: assert property (!$stable(output_bus_chan_b) |->
		$past(shared_read_clock, 2)) else $error("data b moved without read edge");
	AST_OE_A_READ_EDGE: assert property (!$stable(output_bus_oe_chan_a) |->
		$past(shared_read_clock, 2) && !(cascade_select ? $past(read_pointer_clear_a, 10) :
		$past(read_pointer_clear_a, 2))) else $error("oe a moved off a read edge");
	AST_OE_A_DRIVE: assert property (!$stable(output_bus_oe_chan_a) |->
		output_bus_oe_chan_a == (cascade_select ? $past(output_drive_chan_a, 10) : $past(output_drive_chan_a, 2)))
		else $error("oe a differs from drive");

	////////////////////////////////////////////////////////////////////////////////
	// controller side of the pins
	AST_WR_CTL_STABLE: assert property ($rose(write_clock_chan_a) |-> $stable(write_gate_chan_a) &&
		$stable(write_mask_chan_a) && $stable(input_bus_chan_a) && $stable(write_pointer_clear_a))
		else $error("write controls moved at write edge");
	AST_WR_CLEAR_LOW: assert property ($fell(write_pointer_clear_a) |->
		!write_pointer_clear_a [*8] ##1 !write_pointer_clear_a [*8]) else $error("write clear low too short");
	AST_RD_CLEAR_LOW: assert property ($fell(read_pointer_clear_a) |->
		!read_pointer_clear_a [*8] ##1 !read_pointer_clear_a [*8]) else $error("read clear low too short");
endmodule // dfdf_pins_sva

// ==== tb/testbench.sv ====
// self-checking bench: host end and device end joined by dfdf_if
// assumes serial period of 8 system cycles as set in dfdf_map.svh
`timescale 1ns/10ps

module testbench;
	logic                 clock;
	logic                 rst_n;
	logic                 cas;
	dfdf_pkg::dfdf_word_t wd   [2];
	dfdf_pkg::dfdf_word_t rdat [2];
	dfdf_pkg::dfdf_word_t ea   [8];
	logic [1:0]           wg, wm, wc, wt, rg, rdr, rc, rt, rv;
	int                   n_mismatch, compares;

	dfdf_if bus ();
	dfdf_device dfdf_device_inst (.clock(clock), .rst_n(rst_n), .cascade_select(cas), .pins(bus));
	dfdf_host dfdf_host_inst (.clock(clock), .rst_n(rst_n), .pins(bus), .host_wr_data(wd), .host_wr_gate(wg),
		.host_wr_mask(wm), .host_wr_clear(wc), .host_wr_taken(wt), .host_rd_gate(rg), .host_rd_drive(rdr),
		.host_rd_clear(rc), .host_rd_taken(rt), .host_rd_data(rdat), .host_rd_valid(rv));
	dfdf_pins_sva dfdf_pins_sva_inst (.clock(clock), .rst_n(rst_n), .cascade_select(cas),
		.write_clock_chan_a(bus.write_clock_chan_a),
		.shared_read_clock(bus.shared_read_clock), .write_gate_chan_a(bus.write_gate_chan_a),
		.write_mask_chan_a(bus.write_mask_chan_a), .write_pointer_clear_a(bus.write_pointer_clear_a),
		.read_pointer_clear_a(bus.read_pointer_clear_a), .read_gate_chan_a(bus.read_gate_chan_a),
		.output_drive_chan_a(bus.output_drive_chan_a), .input_bus_chan_a(bus.input_bus_chan_a),
		.output_bus_chan_a(bus.output_bus_chan_a), .output_bus_chan_b(bus.output_bus_chan_b),
		.output_bus_oe_chan_a(bus.output_bus_oe_chan_a));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input dfdf_pkg::dfdf_word_t seen, input dfdf_pkg::dfdf_word_t exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// k: 0 write taken, 1 read taken, 2 read valid; a refused clear may wait three periods
	task automatic wait_hi(input int ch, input int k);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while ((k == 0 ? wt[ch] : k == 1 ? rt[ch] : rv[ch]) !== 1'b1 && n < 40);
		check(8'(n < 40), 8'h01);
	endtask

	task automatic wr(input int ch, input logic g, input logic m, input logic c, input dfdf_pkg::dfdf_word_t d);
		@(negedge clock);
		wg[ch] = g;
		wm[ch] = m;
		wc[ch] = c;
		wd[ch] = d;
		wait_hi(ch, 0);
		wg[ch] = 1'b0;
		wm[ch] = 1'b0;
		wc[ch] = 1'b0;
	endtask

	task automatic rd(input int ch, input logic g, input logic dr, input logic c, input dfdf_pkg::dfdf_word_t e);
		@(negedge clock);
		rg[ch] = g;
		rdr[ch] = dr;
		rc[ch] = c;
		wait_hi(ch, 1);
		rg[ch] = 1'b0;
		rc[ch] = 1'b0;
		if (g && dr && !c) begin
			wait_hi(ch, 2);
			check(rdat[ch], e);
		end
	endtask

	// clear with gate high and a drive level; the oe level must survive the clear edge
	task automatic t_clear(input logic dr);
		logic o;
		@(negedge clock);
		rc[0] = 1'b1;
		rg[0] = 1'b1;
		rdr[0] = dr;
		wait_hi(0, 1);
		o = bus.output_bus_oe_chan_a;
		rc[0] = 1'b0;
		rg[0] = 1'b0;
		repeat (9) @(negedge clock);
		check(8'(bus.output_bus_oe_chan_a), 8'(o));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_fill;
		for (int ch = 0; ch < 2; ch++) begin
			wr(ch, 1'b1, 1'b1, 1'b1, 8'hEE);
			for (int i = 0; i < 8; i++) begin
				ea[i] = 8'(8'h10 + i);
				wr(ch, 1'b1, 1'b1, 1'b0, ch ? 8'(8'h80 + i) : ea[i]);
			end
		end
		repeat (200) @(negedge clock);
		rd(0, 1'b0, 1'b0, 1'b1, 8'h00);
		rd(1, 1'b0, 1'b0, 1'b1, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rd(0, 1'b1, 1'b1, 1'b0, ea[i]);
			rd(1, 1'b1, 1'b1, 1'b0, 8'(8'h80 + i));
		end
		check(8'(bus.output_bus_oe_chan_b), 8'h01);
		$display("t_fill done");
	endtask

	task automatic t_mask;
		wr(0, 1'b1, 1'b1, 1'b1, 8'h55);
		for (int i = 0; i < 8; i++) begin
			if (i == 3)
				wr(0, 1'b0, 1'b1, 1'b0, 8'hEE);
			wr(0, 1'b1, !i[0], 1'b0, 8'(8'hA0 + i));
			if (!i[0])
				ea[i] = 8'(8'hA0 + i);
		end
		t_clear(1'b0);
		t_clear(1'b1);
		for (int i = 0; i < 8; i++)
			rd(0, 1'b1, 1'b1, 1'b0, ea[i]);
		$display("t_mask done");
	endtask

	task automatic t_rdgate;
		t_clear(1'b0);
		rd(0, 1'b1, 1'b1, 1'b0, ea[0]);
		rd(0, 1'b0, 1'b1, 1'b0, 8'h00);
		rd(0, 1'b1, 1'b0, 1'b0, 8'h00);
		repeat (9) @(negedge clock);
		check(8'(bus.output_bus_oe_chan_a), 8'h00);
		rd(0, 1'b1, 1'b1, 1'b0, ea[2]);
		$display("t_rdgate done");
	endtask

	// cascade strap under a second reset: the host still collects one edge early,
	// so it sees the reset data word; the addressed word shows one edge later
	task automatic t_cascade;
		@(negedge clock);
		rst_n = 1'b0;
		cas = 1'b1;
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		rd(0, 1'b0, 1'b0, 1'b1, 8'h00);
		rd(0, 1'b1, 1'b1, 1'b0, 8'h00);
		repeat (4) @(negedge clock);
		check(bus.output_bus_chan_a, ea[0]);
		$display("t_cascade done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end

	initial begin
		n_mismatch = 0;
		compares = 0;
		rst_n = 1'b0;
		cas = 1'b0;
		{wg, wm, wc, rg, rdr, rc} = '0;
		wd = '{8'h00, 8'h00};
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		t_fill();
		t_mask();
		t_rdgate();
		t_cascade();
		summarize();
	end
endmodule // testbench
